// ### gpio_system_functions.sv
`timescale 1ns/10ps
module gpio_system_functions
  import gpio_sys_pkg::*;
#(
  parameter int NUM_PINS    = NUM_PINS_DEF,
  parameter int NUM_RAILS   = NUM_RAILS_DEF,
  parameter int NUM_TYPES   = NUM_TYPES_DEF,
  parameter int NUM_BLOCKS  = NUM_BLOCKS_DEF,
  parameter int TICK_CYCLES = MS_CYCLES_DEF
)
(
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [11:0]                   paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic [NUM_PINS-1:0]           pin_in,
  output logic      [NUM_PINS-1:0]           pin_out,
  output logic      [NUM_PINS-1:0]           pin_oe,
  input  wire logic                          bus_control_input,
  input  wire logic [NUM_RAILS-1:0]          rail_enable_req,
  input  wire logic [NUM_RAILS-1:0]          rail_power_good,
  input  wire logic [NUM_TYPES*NUM_RAILS-1:0] rail_status,
  input  wire logic                          seq_done,
  input  wire logic                          power_down_active,
  output logic                               seq_start_allow,
  output logic                               margin_active,
  output logic                               margin_up
);
  localparam int NT = NUM_BLOCKS * TERMS_PER_BLOCK;
  localparam int TW = $clog2(TICK_CYCLES + 1);

  if (NUM_PINS > 32 || NUM_PINS < 1 || NUM_RAILS > 16 || NUM_TYPES > 32 || NUM_BLOCKS > 16 || TICK_CYCLES < 1)
  begin : g_bad
    $error("gpio_system_functions: unsupported parameters");
  end

  typedef enum logic [1:0] {SR_IDLE, SR_DELAY, SR_PULSE, SR_DONE} sr_state_t;
  typedef enum logic [1:0] {WD_OFF, WD_INIT, WD_RUN, WD_EXPIRED} wd_state_t;

  function automatic logic [21:0] shift_ms(input int base, input logic [4:0] code);
    logic [21:0] v;
    v = '0;
    if (code != 5'h00)
      v = 22'(base) << (code - 5'h01);
    return v;
  endfunction : shift_ms

  function automatic logic [31:0] to_word(input logic [NUM_PINS-1:0] v);
    logic [31:0] w;
    w = '0;
    w[NUM_PINS-1:0] = v;
    return w;
  endfunction : to_word

  pin_cfg_t               pin_cfg_reg [NUM_PINS];
  logic [31:0]            term_gpi_reg [NT];
  logic [31:0]            term_rail_reg [NT];
  logic [NUM_RAILS-1:0]   pg_mask_reg;
  logic [2:0]             margin_ctrl_reg;
  logic [31:0]            sr_cfg_reg;
  logic [15:0]            sr_dly_reg;
  logic [23:0]            wdt_cfg_reg;
  logic [NUM_RAILS-1:0]   latch_reg [NUM_TYPES];
  logic [NUM_PINS-1:0]    sync1_reg, sync2_reg, sync3_reg, filt_reg;
  logic                   bc1_reg, bc2_reg, bc3_reg, bc_filt_reg;
  logic                   kick_prev_reg;
  logic [TW-1:0]          tick_cnt_reg;
  logic                   ms_tick;
  sr_state_t              sr_state_reg;
  logic [16:0]            sr_cnt_reg;
  wd_state_t              wd_state_reg;
  logic [21:0]            wd_cnt_reg;
  logic [31:0]            prdata_reg;
  logic                   pslverr_reg;
  logic [NUM_PINS-1:0]    pin_out_reg, pin_oe_reg;
  logic                   pg_out_reg, margin_active_reg, margin_up_reg;

  // apb decode
  logic        apb_wr, apb_setup, hit, refuse;
  logic [31:0] rd_val;
  logic        is_pin, is_term;
  int          pin_idx, term_idx;
  logic        term_hi;
  int          en_count, en_other;
  assign apb_wr    = psel & penable & pwrite;
  assign apb_setup = psel & ~penable;

  always_comb
  begin
    en_count = 0;
    en_other = 0;
    for (int i = 0; i < NUM_PINS; i++)
    begin
      if (pin_cfg_reg[i].func == FN_RAIL_EN)
      begin
        en_count = en_count + 1;
        if (i != pin_idx || !is_pin)
          en_other = en_other + 1;
      end
    end
  end

  always_comb
  begin
    hit      = 1'b1;
    rd_val   = '0;
    is_pin   = 1'b0;
    is_term  = 1'b0;
    pin_idx  = (int'(paddr) - int'(OFS_PIN_BASE)) >>> 2;
    term_idx = (int'(paddr) - int'(OFS_TERM_BASE)) >>> 3;
    term_hi  = paddr[2];
    case (paddr)
      OFS_STATUS:
      begin
        rd_val[0] = pg_out_reg;
        rd_val[1] = seq_start_allow;
        rd_val[2] = margin_active_reg;
        rd_val[3] = margin_up_reg;
        rd_val[ST_WDT_LSB +: 2] = wd_state_reg;
        rd_val[ST_SR_LSB +: 2]  = sr_state_reg;
        rd_val[ST_CNT_LSB +: 8] = 8'(en_count);
      end
      OFS_PIN_IN:    rd_val = to_word(filt_reg);
      OFS_PG_MASK:   rd_val[NUM_RAILS-1:0] = pg_mask_reg;
      OFS_MARGIN:    rd_val[2:0] = margin_ctrl_reg;
      OFS_SR_CFG:    rd_val = sr_cfg_reg;
      OFS_SR_DLY:    rd_val[15:0] = sr_dly_reg;
      OFS_WDT_CFG:   rd_val[23:0] = wdt_cfg_reg;
      OFS_WDT_KICK:  rd_val = '0;
      OFS_LATCH_CLR: rd_val = '0;
      default:
      begin
        if (paddr[1:0] == 2'h0 && pin_idx >= 0 && pin_idx < NUM_PINS)
        begin
          is_pin = 1'b1;
          rd_val = pin_cfg_reg[pin_idx];
        end
        else if (paddr[1:0] == 2'h0 && term_idx >= 0 && term_idx < NT)
        begin
          is_term = 1'b1;
          rd_val  = term_hi ? term_rail_reg[term_idx] : term_gpi_reg[term_idx];
        end
        else
          hit = 1'b0;
      end
    endcase
  end

  assign refuse = is_pin && pwdata[3:0] == FN_RAIL_EN && en_other >= MAX_RAIL_EN;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_reg  <= '0;
      pslverr_reg <= 1'b0;
    end
    else if (apb_setup)
    begin
      prdata_reg  <= pwrite ? 32'h0000_0000 : rd_val;
      pslverr_reg <= ~hit | (pwrite & refuse);
    end
  end
  assign prdata  = prdata_reg;
  assign pslverr = pslverr_reg & psel & penable;
  assign pready  = 1'b1;

  // configuration registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < NUM_PINS; i++)
        pin_cfg_reg[i] <= FAST_PWM_OUTPUT_MASK[i] ? PIN_CFG_FAST_PWM_OUTPUT_RST : PIN_CFG_RST;
      for (int t = 0; t < NT; t++)
      begin
        term_gpi_reg[t]  <= '0;
        term_rail_reg[t] <= '0;
      end
      pg_mask_reg     <= '1;
      margin_ctrl_reg <= '0;
      sr_cfg_reg      <= '0;
      sr_dly_reg      <= '0;
      wdt_cfg_reg     <= '0;
    end
    else if (apb_wr && !pslverr_reg)
    begin
      case (paddr)
        OFS_PG_MASK: pg_mask_reg     <= pwdata[NUM_RAILS-1:0];
        OFS_MARGIN:  margin_ctrl_reg <= pwdata[2:0];
        OFS_SR_CFG:  sr_cfg_reg      <= pwdata;
        OFS_SR_DLY:  sr_dly_reg      <= pwdata[15:0];
        OFS_WDT_CFG: wdt_cfg_reg     <= pwdata[23:0];
        default:
        begin
          if (is_pin)
            pin_cfg_reg[pin_idx] <= pwdata;
          else if (is_term && term_hi)
            term_rail_reg[term_idx] <= pwdata;
          else if (is_term)
            term_gpi_reg[term_idx] <= pwdata;
        end
      endcase
    end
  end

  // input synchronisers, accepted when stages two and three agree
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_reg   <= '0;
      sync2_reg   <= '0;
      sync3_reg   <= '0;
      filt_reg    <= '0;
      bc1_reg     <= 1'b0;
      bc2_reg     <= 1'b0;
      bc3_reg     <= 1'b0;
      bc_filt_reg <= 1'b0;
    end
    else
    begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      for (int i = 0; i < NUM_PINS; i++)
        if (sync2_reg[i] == sync3_reg[i])
          filt_reg[i] <= sync3_reg[i];
      bc1_reg <= bus_control_input;
      bc2_reg <= bc1_reg;
      bc3_reg <= bc2_reg;
      if (bc2_reg == bc3_reg)
        bc_filt_reg <= bc3_reg;
    end
  end
  assign seq_start_allow = bc_filt_reg;

  // special input functions
  logic kick_lvl, clr_pin, marg_en_pin, marg_up_pin, kick_edge, kick_wr;
  always_comb
  begin
    kick_lvl    = 1'b0;
    clr_pin     = 1'b0;
    marg_en_pin = 1'b0;
    marg_up_pin = 1'b0;
    for (int i = 0; i < NUM_PINS; i++)
    begin
      kick_lvl    = kick_lvl    | (filt_reg[i] & pin_cfg_reg[i].func == FN_WDT_KICK);
      clr_pin     = clr_pin     | (filt_reg[i] & pin_cfg_reg[i].func == FN_LATCH_CLR);
      marg_en_pin = marg_en_pin | (filt_reg[i] & pin_cfg_reg[i].func == FN_MARG_EN);
      marg_up_pin = marg_up_pin | (filt_reg[i] & pin_cfg_reg[i].func == FN_MARG_UP);
    end
  end
  assign kick_edge = kick_lvl ^ kick_prev_reg;
  assign kick_wr   = apb_wr && !pslverr_reg && paddr == OFS_WDT_KICK;

  // latched status, a new event wins over a clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      for (int k = 0; k < NUM_TYPES; k++)
        latch_reg[k] <= '0;
    else
      for (int k = 0; k < NUM_TYPES; k++)
        latch_reg[k] <= rail_status[k*NUM_RAILS +: NUM_RAILS] |
                        (latch_reg[k] & ~{NUM_RAILS{clr_pin | (apb_wr && !pslverr_reg &&
                                          paddr == OFS_LATCH_CLR && pwdata[k])}});
  end

  // boolean blocks
  logic [NUM_BLOCKS-1:0] block_out;
  always_comb
  begin
    logic [NUM_RAILS-1:0] flags;
    logic [NUM_RAILS-1:0] rmask;
    logic [NUM_PINS-1:0]  gmask;
    logic [4:0]           ty;
    flags     = '0;
    rmask     = '0;
    gmask     = '0;
    ty        = '0;
    block_out = '0;
    for (int t = 0; t < NT; t++)
    begin
      ty    = term_rail_reg[t][TYPE_LSB +: 5];
      rmask = term_rail_reg[t][NUM_RAILS-1:0];
      gmask = term_gpi_reg[t][NUM_PINS-1:0];
      flags = '0;
      if (int'(ty) < NUM_TYPES)
        flags = term_rail_reg[t][TYPE_LATCH_BIT] ? latch_reg[ty] : rail_status[ty*NUM_RAILS +: NUM_RAILS];
      if ((|rmask || |gmask) && &(filt_reg | ~gmask) && &(flags | ~rmask))
        block_out[t / TERMS_PER_BLOCK] = 1'b1;
    end
  end

  // millisecond tick
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tick_cnt_reg <= '0;
    else if (ms_tick)
      tick_cnt_reg <= '0;
    else
      tick_cnt_reg <= tick_cnt_reg + 1'b1;
  end
  assign ms_tick = tick_cnt_reg == TW'(TICK_CYCLES - 1);

  // system reset sequencer
  logic [NUM_RAILS-1:0] sr_mask;
  logic                 sr_pg, wd_fire, wd_to_reset;
  logic [21:0]          sr_width;
  assign sr_mask     = sr_cfg_reg[NUM_RAILS-1:0];
  assign sr_pg       = |sr_mask && &(rail_power_good | ~sr_mask);
  assign sr_width    = sr_cfg_reg[SR_CODE_LSB +: 5] < 5'(RST_WIDTH_CODES) ?
                       shift_ms(RST_BASE_MS, sr_cfg_reg[SR_CODE_LSB +: 5]) : '0;
  assign wd_to_reset = wdt_cfg_reg[WDT_ACT_BIT];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sr_state_reg <= SR_IDLE;
      sr_cnt_reg   <= '0;
    end
    else if (wd_fire && wd_to_reset && sr_state_reg != SR_PULSE && sr_width != '0)
    begin
      sr_state_reg <= SR_PULSE;
      sr_cnt_reg   <= '0;
    end
    else
    begin
      if (ms_tick)
        sr_cnt_reg <= sr_cnt_reg + 1'b1;
      case (sr_state_reg)
        SR_IDLE:
          if (sr_pg)
          begin
            sr_state_reg <= SR_DELAY;
            sr_cnt_reg   <= '0;
          end
        SR_DELAY:
          if (!sr_pg)
            sr_state_reg <= SR_IDLE;
          else if (sr_cnt_reg >= {1'b0, sr_dly_reg})
          begin
            sr_state_reg <= sr_width == '0 ? SR_DONE : SR_PULSE;
            sr_cnt_reg   <= '0;
          end
        SR_PULSE:
          if (22'(sr_cnt_reg) >= sr_width)
            sr_state_reg <= SR_DONE;
        SR_DONE:
          if (!sr_pg)
            sr_state_reg <= SR_IDLE;
        default:
          sr_state_reg <= SR_IDLE;
      endcase
    end
  end

  // watchdog
  logic        wd_enable, wd_restart;
  logic [21:0] wd_init, wd_limit;
  assign wd_enable  = wdt_cfg_reg[WDT_EN_BIT] &&
                      (!wdt_cfg_reg[WDT_TIED_BIT] || sr_state_reg == SR_PULSE || sr_state_reg == SR_DONE);
  assign wd_restart = kick_edge | kick_wr;
  assign wd_init    = shift_ms(WDT_INIT_BASE_MS, {1'b0, wdt_cfg_reg[WDT_INIT_LSB +: 4]});
  assign wd_limit   = 22'(wdt_cfg_reg[WDT_TO_LSB +: 8]) * 22'(WDT_STEP_MS);
  assign wd_fire    = wd_state_reg == WD_RUN && !wd_restart && wd_cnt_reg >= wd_limit;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wd_state_reg  <= WD_OFF;
      wd_cnt_reg    <= '0;
      kick_prev_reg <= 1'b0;
    end
    else
    begin
      kick_prev_reg <= kick_lvl;
      if (ms_tick)
        wd_cnt_reg <= wd_cnt_reg + 1'b1;
      if (!wd_enable)
        wd_state_reg <= WD_OFF;
      else
        case (wd_state_reg)
          WD_OFF:
          begin
            wd_state_reg <= WD_INIT;
            wd_cnt_reg   <= '0;
          end
          WD_INIT:
            if (wd_restart || wd_cnt_reg >= wd_init)
            begin
              wd_state_reg <= WD_RUN;
              wd_cnt_reg   <= '0;
            end
          WD_RUN:
            if (wd_restart)
              wd_cnt_reg <= '0;
            else if (wd_fire)
              wd_state_reg <= WD_EXPIRED;
          WD_EXPIRED:
            if (wd_restart)
            begin
              wd_state_reg <= WD_RUN;
              wd_cnt_reg   <= '0;
            end
          default:
            wd_state_reg <= WD_OFF;
        endcase
    end
  end

  // margining and power good
  logic mg_en, mg_up;
  assign mg_en = margin_ctrl_reg[MG_SRC_BIT] ? marg_en_pin : margin_ctrl_reg[MG_EN_BIT];
  assign mg_up = margin_ctrl_reg[MG_SRC_BIT] ? marg_up_pin : margin_ctrl_reg[MG_UP_BIT];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pg_out_reg        <= 1'b0;
      margin_active_reg <= 1'b0;
      margin_up_reg     <= 1'b0;
    end
    else
    begin
      pg_out_reg        <= seq_done & ~power_down_active & (&(rail_power_good | ~pg_mask_reg));
      margin_active_reg <= mg_en;
      margin_up_reg     <= mg_up;
    end
  end
  assign margin_active = margin_active_reg;
  assign margin_up     = margin_up_reg;

  // pin output stage
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_out_reg <= '0;
      pin_oe_reg  <= FAST_PWM_OUTPUT_MASK[NUM_PINS-1:0];
    end
    else
      for (int i = 0; i < NUM_PINS; i++)
      begin
        logic a, lvl, drv;
        int   s;
        s   = int'(pin_cfg_reg[i].sel);
        a   = 1'b0;
        drv = 1'b1;
        case (pin_cfg_reg[i].func)
          FN_RAIL_EN:  a = s < NUM_RAILS && rail_enable_req[s];
          FN_LOGIC:    a = s < NUM_BLOCKS && block_out[s];
          FN_PWR_GOOD: a = pg_out_reg;
          FN_SYS_RST:  a = sr_state_reg == SR_PULSE;
          FN_WDT_OUT:  a = wd_state_reg == WD_EXPIRED && !wd_to_reset;
          FN_MARG_VCC: a = margin_active_reg && !margin_up_reg && s < NUM_RAILS && rail_enable_req[s];
          FN_MARG_GND: a = margin_active_reg && margin_up_reg && s < NUM_RAILS && rail_enable_req[s];
          FN_STATIC:   a = pin_cfg_reg[i].value;
          default:     drv = 1'b0;
        endcase
        lvl = a ^ pin_cfg_reg[i].active_low;
        if (!drv)
        begin
          pin_out_reg[i] <= 1'b0;
          pin_oe_reg[i]  <= 1'b0;
        end
        else if (pin_cfg_reg[i].open_drain)
        begin
          pin_out_reg[i] <= 1'b0;
          pin_oe_reg[i]  <= ~lvl;
        end
        else
        begin
          pin_out_reg[i] <= lvl;
          pin_oe_reg[i]  <= 1'b1;
        end
      end
  end
  assign pin_out = pin_out_reg;
  assign pin_oe  = pin_oe_reg;
endmodule : gpio_system_functions

// ### gpio_sys_pkg.sv
package gpio_sys_pkg;
  // sizes
  localparam int NUM_PINS_DEF    = 26;
  localparam int NUM_RAILS_DEF   = 13;
  localparam int NUM_TYPES_DEF   = 17;
  localparam int NUM_BLOCKS_DEF  = 4;
  localparam int TERMS_PER_BLOCK = 4;
  localparam int MAX_RAIL_EN     = 12;
  localparam logic [31:0] FAST_PWM_OUTPUT_MASK = 32'h0000_0FF0;
  // pin functions
  localparam logic [3:0] FN_INPUT     = 4'h0;
  localparam logic [3:0] FN_RAIL_EN   = 4'h1;
  localparam logic [3:0] FN_LOGIC     = 4'h2;
  localparam logic [3:0] FN_PWR_GOOD  = 4'h3;
  localparam logic [3:0] FN_SYS_RST   = 4'h4;
  localparam logic [3:0] FN_WDT_OUT   = 4'h5;
  localparam logic [3:0] FN_MARG_VCC  = 4'h6;
  localparam logic [3:0] FN_MARG_GND  = 4'h7;
  localparam logic [3:0] FN_STATIC    = 4'h8;
  localparam logic [3:0] FN_WDT_KICK  = 4'h9;
  localparam logic [3:0] FN_LATCH_CLR = 4'hA;
  localparam logic [3:0] FN_MARG_EN   = 4'hB;
  localparam logic [3:0] FN_MARG_UP   = 4'hC;
  // register byte offsets
  localparam logic [11:0] OFS_STATUS    = 12'h000;
  localparam logic [11:0] OFS_PIN_IN    = 12'h004;
  localparam logic [11:0] OFS_PG_MASK   = 12'h008;
  localparam logic [11:0] OFS_MARGIN    = 12'h00C;
  localparam logic [11:0] OFS_SR_CFG    = 12'h010;
  localparam logic [11:0] OFS_SR_DLY    = 12'h014;
  localparam logic [11:0] OFS_WDT_CFG   = 12'h018;
  localparam logic [11:0] OFS_WDT_KICK  = 12'h01C;
  localparam logic [11:0] OFS_LATCH_CLR = 12'h020;
  localparam logic [11:0] OFS_PIN_BASE  = 12'h100;
  localparam logic [11:0] OFS_TERM_BASE = 12'h200;
  // field positions
  localparam int MG_SRC_BIT     = 0;
  localparam int MG_EN_BIT      = 1;
  localparam int MG_UP_BIT      = 2;
  localparam int SR_CODE_LSB    = 16;
  localparam int WDT_EN_BIT     = 0;
  localparam int WDT_TIED_BIT   = 1;
  localparam int WDT_ACT_BIT    = 2;
  localparam int WDT_INIT_LSB   = 8;
  localparam int WDT_TO_LSB     = 16;
  localparam int TYPE_LSB       = 16;
  localparam int TYPE_LATCH_BIT = 21;
  localparam int ST_WDT_LSB     = 8;
  localparam int ST_SR_LSB      = 12;
  localparam int ST_CNT_LSB     = 16;
  // timing
  localparam int CLK_PERIOD_NS    = 100;
  localparam int MS_NS            = 1000000;
  localparam int MS_CYCLES_DEF    = MS_NS / CLK_PERIOD_NS;
  localparam int RST_BASE_MS      = 1;
  localparam int WDT_INIT_BASE_MS = 100;
  localparam int WDT_STEP_MS      = 10;
  localparam int RST_WIDTH_CODES  = 17;
  localparam int WDT_INIT_CODES   = 16;
  typedef struct packed {
    logic [19:0] rsvd_hi;
    logic [3:0]  sel;
    logic        rsvd_lo;
    logic        value;
    logic        open_drain;
    logic        active_low;
    logic [3:0]  func;
  } pin_cfg_t;
  localparam pin_cfg_t PIN_CFG_RST      = 32'h0000_0000;
  localparam pin_cfg_t PIN_CFG_FAST_PWM_OUTPUT_RST = 32'h0000_0008;
endpackage : gpio_sys_pkg

// ### gpio_sys_props.sv
`timescale 1ns/10ps
module gpio_sys_props
  import gpio_sys_pkg::*;
#(
  parameter int NUM_PINS  = 26,
  parameter int NUM_RAILS = 13
)
(
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [11:0]          paddr,
  input wire logic [31:0]          pwdata,
  input wire logic                 pslverr,
  input wire logic [NUM_PINS-1:0]  pin_in,
  input wire logic [NUM_PINS-1:0]  pin_out,
  input wire logic [NUM_PINS-1:0]  pin_oe,
  input wire logic                 bus_control_input,
  input wire logic [NUM_RAILS-1:0] rail_enable_req,
  input wire logic                 power_down_active,
  input wire logic                 seq_start_allow,
  input wire logic                 margin_active
);
  pin_cfg_t   cfg [4];
  logic       lvl_q;
  logic [2:0] quiet;
  logic       rst_seen;
  function automatic logic pp_hi(pin_cfg_t c, logic [3:0] f);
    return c.func == f && !c.active_low && !c.open_drain;
  endfunction : pp_hi
  // shadow of pin configs 0 to 3
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg      <= '{default: PIN_CFG_RST};
      rst_seen <= 1'b1;
    end
    else if (psel && penable && pwrite && !pslverr && paddr[11:4] == 8'h10)
      cfg[paddr[3:2]] <= pwdata;
  end
  // pin 0 rail enable level (rail chosen by its sel), quiet time of pins and bus
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lvl_q <= 1'b0;
      quiet <= 3'h0;
    end
    else
    begin
      lvl_q <= rail_enable_req[cfg[0].sel] ^ cfg[0].active_low;
      quiet <= (psel || !$stable(pin_in)) ? 3'h0 : quiet + 3'(quiet != 3'h7);
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rst_pins; disable iff (1'b0)
    !presetn && rst_seen |-> pin_oe == NUM_PINS'(FAST_PWM_OUTPUT_MASK) && pin_out == '0; endproperty
  a_rst_pins: assert property (p_rst_pins) else $error("pins not idle in reset");
  property p_slave_hold; !bus_control_input [*8] |-> !seq_start_allow; endproperty
  a_slave_hold: assert property (p_slave_hold) else $error("start allowed early");
  property p_slave_go; bus_control_input [*8] |-> seq_start_allow; endproperty
  a_slave_go: assert property (p_slave_go) else $error("start not allowed");
  property p_err_phase; pslverr |-> psel && penable; endproperty
  a_err_phase: assert property (p_err_phase) else $error("error outside access");
  property p_rail_en; cfg[0].func == FN_RAIL_EN && $stable(cfg[0]) |->
    pin_oe[0] == (!cfg[0].open_drain || !lvl_q) && pin_out[0] == (lvl_q && !cfg[0].open_drain); endproperty
  a_rail_en: assert property (p_rail_en) else $error("rail enable pin wrong");
  property p_pg_drop; pp_hi(cfg[1], FN_PWR_GOOD) && power_down_active |-> ##[1:2] !pin_out[1]; endproperty
  a_pg_drop: assert property (p_pg_drop) else $error("power good kept");
  property p_marg; (pp_hi(cfg[2], FN_MARG_GND) && !margin_active) [*3] |-> !pin_out[2]; endproperty
  a_marg: assert property (p_marg) else $error("margin pin without margin");
  property p_wdt_hold; pp_hi(cfg[3], FN_WDT_OUT) && $stable(cfg[3]) && pin_out[3] && quiet == 3'h7
    |=> pin_out[3]; endproperty
  a_wdt_hold: assert property (p_wdt_hold) else $error("timeout pin dropped");
  c_refused: cover property (pslverr && pwrite);
  c_slave: cover property ($rose(seq_start_allow));
  c_wdt: cover property (pp_hi(cfg[3], FN_WDT_OUT) && $rose(pin_out[3]));
endmodule : gpio_sys_props
bind gpio_system_functions gpio_sys_props #(.NUM_PINS(NUM_PINS), .NUM_RAILS(NUM_RAILS)) u_props (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pslverr, .pin_in, .pin_out, .pin_oe,
  .bus_control_input, .rail_enable_req, .power_down_active, .seq_start_allow, .margin_active);

// ### supply_model.sv
`timescale 1ns/10ps
module supply_model
#(
  parameter int DLY = 6
)
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic en,
  output logic      pg
);
  logic [3:0] cnt;
  // rail ramps after its enable, drops at once
  always_ff @(posedge pclk)
  begin
    cnt <= (en && presetn) ? cnt + 4'(cnt != 4'hF) : 4'h0;
  end
  assign pg = en && cnt >= 4'(DLY);
endmodule : supply_model

// ### testbench.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fails++; $display("wrong value %s exp %0h got %0h", n, e, g); end end
module testbench
  import gpio_sys_pkg::*;
;
  logic         pclk;
  logic         presetn = 0;
  logic         psel = 0;
  logic         penable = 0;
  logic         pwrite = 0;
  logic [11:0]  paddr = '0;
  logic [31:0]  pwdata = '0;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic [25:0]  drv = '0;
  logic [25:0]  pin_out;
  logic [25:0]  pin_oe;
  logic [12:0]  req = '0;
  logic [220:0] rs = '0;
  logic         seq_done = 0;
  logic         pda = 0;
  logic         go;
  logic         m_act;
  logic         m_up;
  logic         pg;
  logic [31:0]  rv;
  int           fails = 0;
  int           check_count = 0;
  wire logic [3:0] lvl = ~pin_oe[3:0] | pin_out[3:0];
  gpio_system_functions #(.TICK_CYCLES(4)) u_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .pin_in({drv[25:4], lvl}), .pin_out, .pin_oe, .bus_control_input(pg), .rail_enable_req(req),
    .rail_power_good({12'h000, pg}), .rail_status(rs), .seq_done, .power_down_active(pda),
    .seq_start_allow(go), .margin_active(m_act), .margin_up(m_up));
  supply_model u_sup (.pclk, .presetn, .en(lvl[0]), .pg);
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  task automatic w(input int n);
    repeat (n) @(posedge pclk);
  endtask : w
  task automatic xf(input logic [11:0] a, input logic wr, input logic [31:0] d, input logic xe);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    `CHK("pslverr", xe, pslverr)
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xf
  task automatic pc(input int i, input logic [3:0] f, input logic [1:0] m, input logic xe = 1'b0);
    xf(OFS_PIN_BASE + 12'(4 * i), 1'b1, {26'h0, m, f}, xe);
  endtask : pc
  task automatic end_sim;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  initial
  begin
    w(5000);
    fails++;
    end_sim();
  end
  initial
  begin
    w(5);
    `CHK("reset oe", 26'(FAST_PWM_OUTPUT_MASK), pin_oe)
    presetn <= 1'b1;
    xf(OFS_PG_MASK, 1'b0, '0, 1'b0);
    `CHK("pg mask", 32'h0000_1FFF, rv)
    xf(12'h0FC, 1'b1, '1, 1'b1);
    for (int i = 4; i < 15; i++)
      pc(i, FN_RAIL_EN, 2'h0);
    for (int k = 0; k < 8; k++)
    begin
      pc(0, FN_RAIL_EN, k[2:1]);
      req[0] <= k[0];
      w(3);
      `CHK("en oe", !k[2] || !(k[0] ^ k[1]), pin_oe[0])
      `CHK("en out", !k[2] && (k[0] ^ k[1]), pin_out[0])
    end
    pc(15, FN_RAIL_EN, 2'h0, 1'b1);
    xf(OFS_STATUS, 1'b0, '0, 1'b0);
    `CHK("rail en count", 8'h0C, rv[23:16])
    w(10);
    pc(0, FN_RAIL_EN, 2'h0);
    w(2);
    `CHK("slave hold", 1'b0, go)
    w(16);
    `CHK("slave go", 1'b1, go)
    pc(1, FN_PWR_GOOD, 2'h0);
    xf(OFS_PG_MASK, 1'b1, 32'h0000_0001, 1'b0);
    seq_done <= 1'b1;
    w(4);
    `CHK("pg subset", 1'b1, pin_out[1])
    pda <= 1'b1;
    w(3);
    `CHK("pg drop", 1'b0, pin_out[1])
    pda <= 1'b0;
    pc(24, FN_LOGIC, 2'h0);
    xf(OFS_TERM_BASE, 1'b1, 32'h0200_0000, 1'b0);
    xf(OFS_TERM_BASE + 12'h004, 1'b1, 32'h0000_0001, 1'b0);
    drv[25] <= 1'b1;
    w(6);
    `CHK("and term", 1'b0, pin_out[24])
    rs[0] <= 1'b1;
    w(3);
    `CHK("and term", 1'b1, pin_out[24])
    rs[0] <= 1'b0;
    xf(OFS_TERM_BASE + 12'h008, 1'b1, 32'h0008_0000, 1'b0);
    drv[19] <= 1'b1;
    w(6);
    `CHK("or term", 1'b1, pin_out[24])
    drv[19] <= 1'b0;
    xf(OFS_TERM_BASE + 12'h004, 1'b1, 32'h0020_0001, 1'b0);
    rs[0] <= 1'b1;
    w(2);
    rs[0] <= 1'b0;
    w(6);
    `CHK("latched", 1'b1, pin_out[24])
    xf(OFS_LATCH_CLR, 1'b1, 32'h0000_0001, 1'b0);
    w(3);
    `CHK("cleared", 1'b0, pin_out[24])
    pc(2, FN_MARG_GND, 2'h0);
    xf(OFS_MARGIN, 1'b1, 32'h0000_0006, 1'b0);
    w(3);
    `CHK("margin reg", 3'h7, {m_act, m_up, pin_out[2]})
    pc(16, FN_MARG_EN, 2'h0);
    pc(17, FN_MARG_UP, 2'h0);
    pc(21, FN_MARG_VCC, 2'h0);
    drv[16] <= 1'b1;
    xf(OFS_MARGIN, 1'b1, 32'h0000_0001, 1'b0);
    w(6);
    `CHK("margin pins", 4'h9, {m_act, m_up, pin_out[2], pin_out[21]})
    pc(3, FN_WDT_OUT, 2'h0);
    pc(18, FN_WDT_KICK, 2'h0);
    xf(OFS_WDT_CFG, 1'b1, 32'h0001_0101, 1'b0);
    w(380);
    xf(OFS_STATUS, 1'b0, '0, 1'b0);
    `CHK("wdt init", 2'h1, rv[9:8])
    w(80);
    `CHK("wdt expired", 1'b1, pin_out[3])
    w(60);
    `CHK("wdt stays", 1'b1, pin_out[3])
    for (int k = 0; k < 2; k++)
    begin
      drv[18] <= !drv[18];
      w(8);
      `CHK("kick pin", 1'b0, pin_out[3])
      w(30);
      `CHK("timeout", 1'b0, pin_out[3])
      w(20);
      `CHK("timeout", 1'b1, pin_out[3])
    end
    xf(OFS_WDT_KICK, 1'b1, '0, 1'b0);
    w(3);
    `CHK("kick write", 1'b0, pin_out[3])
    pc(20, FN_SYS_RST, 2'h0);
    xf(OFS_WDT_CFG, 1'b1, 32'h0001_0007, 1'b0);
    xf(OFS_SR_DLY, 1'b1, 32'h0000_0003, 1'b0);
    xf(OFS_SR_CFG, 1'b1, 32'h0003_0001, 1'b0);
    w(2);
    `CHK("rst delay", 1'b0, pin_out[20])
    w(16);
    `CHK("rst pulse", 1'b1, pin_out[20])
    w(17);
    `CHK("rst end", 1'b0, pin_out[20])
    w(25);
    `CHK("wdt reset", 1'b1, pin_out[20])
    `CHK("wdt pin off", 1'b0, pin_out[3])
    end_sim();
  end
endmodule : testbench
